/* rtl/pcd_pkg.sv */
package pcd_pkg;
    // Command codes
    localparam logic [7:0] CMD_CHANNEL_SELECT  = 8'h00;
    localparam logic [7:0] CMD_RUN_MODE        = 8'h01;
    localparam logic [7:0] CMD_ON_SOURCE       = 8'h02;
    localparam logic [7:0] CMD_FAULT_CLEAR     = 8'h03;
    localparam logic [7:0] CMD_DIRECT_WRITE    = 8'h05;
    localparam logic [7:0] CMD_DIRECT_READ     = 8'h06;
    localparam logic [7:0] CMD_GUARD_LEVEL     = 8'h10;
    localparam logic [7:0] CMD_NVM_SAVE        = 8'h15;
    localparam logic [7:0] CMD_NVM_RELOAD      = 8'h16;
    localparam logic [7:0] CMD_FEATURES        = 8'h19;
    localparam logic [7:0] CMD_ALERT_MASK      = 8'h1B;
    localparam logic [7:0] CMD_FORMAT_EXP      = 8'h20;
    localparam logic [7:0] CMD_NOMINAL         = 8'h21;
    localparam logic [7:0] CMD_CEILING         = 8'h24;
    localparam logic [7:0] CMD_UPPER_MARGIN    = 8'h25;
    localparam logic [7:0] CMD_LOWER_MARGIN    = 8'h26;
    localparam logic [7:0] CMD_RESERVED_BASE   = 8'hD0;
    // Reset and fixed values
    localparam logic [7:0]  RST_CHANNEL    = 8'h00;
    localparam logic [7:0]  RST_RUN_MODE   = 8'h40;
    localparam logic [7:0]  RST_ON_SOURCE  = 8'h1E;
    localparam logic [7:0]  RST_GUARD      = 8'h00;
    localparam logic [7:0]  RST_ALERT_MASK = 8'h00;
    localparam logic [7:0]  FEATURES_VALUE = 8'hB0;
    localparam logic [7:0]  FORMAT_VALUE   = 8'h14;
    localparam logic [15:0] RST_NOMINAL    = 16'h1000;
    localparam logic [15:0] RST_CEILING    = 16'h599A;
    localparam logic [15:0] RST_UPPER      = 16'h10CD;
    localparam logic [15:0] RST_LOWER      = 16'h0F33;
    localparam logic [7:0]  PAGE_ALL       = 8'hFF;
    // Guard levels
    localparam logic [7:0] GUARD_ALL   = 8'h80;
    localparam logic [7:0] GUARD_OP    = 8'h40;
    localparam logic [7:0] GUARD_BASIC = 8'h20;
    // Field positions
    localparam int         OP_ON_BIT       = 7;
    localparam int         OP_MARGIN_LSB   = 4;
    localparam logic [1:0] MARGIN_HIGH     = 2'h2;
    localparam logic [1:0] MARGIN_LOW      = 2'h1;
    localparam int         ONOFF_HONOR_BIT = 4;
    localparam int         ONOFF_CMD_BIT   = 3;
    localparam int         ONOFF_PIN_BIT   = 2;
    // Timing
    localparam int NVM_BUSY_CYCLES = 16;
    localparam int NVM_COUNT_W     = 8;

    typedef enum logic [2:0] {
        REQ_SEND, REQ_WRITE, REQ_READ, REQ_PLUS_WRITE, REQ_PLUS_READ
    } pcd_kind_t;
    typedef enum logic {MODE_IDLE, MODE_NVM} pcd_mode_t;

    typedef struct packed {
        pcd_kind_t   kind;
        logic [7:0]  code;
        logic [7:0]  page;
        logic [7:0]  embCode;
        logic [15:0] data;
        logic        pecSent;
        logic        pecGood;
    } pcd_req_t;
    typedef struct packed {
        logic        valid;
        logic        nack;
        logic [15:0] data;
    } pcd_rsp_t;
    typedef struct packed {
        logic commMemoryLogicFault;
        logic busy;
        logic pec;
    } pcd_fault_t;
    typedef struct packed {
        logic [7:0]  runMode;
        logic [7:0]  onSource;
        logic [7:0]  alertMask;
        logic [15:0] nominal;
        logic [15:0] ceiling;
        logic [15:0] upper;
        logic [15:0] lower;
    } pcd_chan_t;
    typedef struct packed {
        pcd_chan_t [1:0] chan;
        logic [7:0]      guard;
    } pcd_user_t;
    typedef struct packed {
        pcd_user_t               user;
        pcd_user_t               image;
        logic [7:0]              chanSel;
        pcd_fault_t              fault;
        pcd_rsp_t                rsp;
        logic [NVM_COUNT_W-1:0]  busyCnt;
        pcd_mode_t               mode;
        logic [1:0]              runMeta;
        logic [1:0]              runSync;
        logic [1:0]              enable;
        logic [1:0][15:0]        target;
    } pcd_state_t;
endpackage

/* rtl/pcd_command_decoder.sv */
`timescale 1ns/1ps
module pcd_command_decoder #(
    parameter int BUSY_CYCLES = pcd_pkg::NVM_BUSY_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              reqValid,
    input  wire pcd_pkg::pcd_req_t req,
    output logic                   reqReady,
    output pcd_pkg::pcd_rsp_t      rsp,
    input  wire logic [1:0]        runPin,
    output logic [1:0]             chanEnable,
    output logic [1:0][15:0]       chanTarget,
    output logic [1:0][7:0]        alertMask,
    output pcd_pkg::pcd_fault_t    fault
);
    import pcd_pkg::*;

    if (BUSY_CYCLES < 1 || BUSY_CYCLES >= (1 << NVM_COUNT_W)) begin : g_bad
        $error("BUSY_CYCLES out of range");
    end

    localparam logic [NVM_COUNT_W-1:0] BUSY_LOAD = NVM_COUNT_W'(BUSY_CYCLES);

    pcd_state_t cur;
    pcd_state_t next_st;

    function automatic logic isChanCode(input logic [7:0] c);
        isChanCode = (c == CMD_RUN_MODE) || (c == CMD_ON_SOURCE) ||
                     (c == CMD_ALERT_MASK) || (c == CMD_NOMINAL) ||
                     (c == CMD_CEILING) || (c == CMD_UPPER_MARGIN) ||
                     (c == CMD_LOWER_MARGIN);
    endfunction

    // Higher guard levels leave fewer codes writable
    function automatic logic guardOk(input logic [7:0] g, input logic [7:0] c);
        case (g)
            GUARD_ALL:   guardOk = 1'b0;
            GUARD_OP:    guardOk = (c == CMD_RUN_MODE);
            GUARD_BASIC: guardOk = (c == CMD_RUN_MODE) || (c == CMD_CHANNEL_SELECT) ||
                                   (c == CMD_ON_SOURCE) || (c == CMD_NOMINAL);
            default:     guardOk = 1'b1;
        endcase
    endfunction

    function automatic pcd_chan_t chanWrite(input pcd_chan_t c, input logic [7:0] code,
                                            input logic [15:0] d);
        chanWrite = c;
        case (code)
            CMD_RUN_MODE:     chanWrite.runMode = d[7:0];
            CMD_ON_SOURCE:    chanWrite.onSource = d[7:0];
            CMD_ALERT_MASK:   chanWrite.alertMask = d[7:0];
            CMD_NOMINAL:      chanWrite.nominal = d;
            CMD_CEILING:      chanWrite.ceiling = d;
            CMD_UPPER_MARGIN: chanWrite.upper = d;
            CMD_LOWER_MARGIN: chanWrite.lower = d;
            default:          chanWrite = c;
        endcase
    endfunction

    function automatic logic [15:0] chanRead(input pcd_chan_t c, input logic [7:0] code);
        case (code)
            CMD_RUN_MODE:     chanRead = {8'h00, c.runMode};
            CMD_ON_SOURCE:    chanRead = {8'h00, c.onSource};
            CMD_ALERT_MASK:   chanRead = {8'h00, c.alertMask};
            CMD_NOMINAL:      chanRead = c.nominal;
            CMD_CEILING:      chanRead = c.ceiling;
            CMD_UPPER_MARGIN: chanRead = c.upper;
            CMD_LOWER_MARGIN: chanRead = c.lower;
            default:          chanRead = 16'h0000;
        endcase
    endfunction

    // Margin choice, then clamp to the ceiling
    function automatic logic [15:0] setpoint(input pcd_chan_t c);
        logic [15:0] s;
        s = c.nominal;
        if (c.runMode[OP_MARGIN_LSB +: 2] == MARGIN_HIGH) begin
            s = c.upper;
        end else if (c.runMode[OP_MARGIN_LSB +: 2] == MARGIN_LOW) begin
            s = c.lower;
        end
        setpoint = (s > c.ceiling) ? c.ceiling : s;
    endfunction

    function automatic logic chanOn(input pcd_chan_t c, input logic pin);
        chanOn = !c.onSource[ONOFF_HONOR_BIT] ||
                 ((!c.onSource[ONOFF_CMD_BIT] || c.runMode[OP_ON_BIT]) &&
                  (!c.onSource[ONOFF_PIN_BIT] || pin));
    endfunction

    function automatic pcd_user_t userReset();
        userReset.guard = RST_GUARD;
        for (int i = 0; i < 2; i++) begin
            userReset.chan[i] = '{runMode: RST_RUN_MODE, onSource: RST_ON_SOURCE,
                                  alertMask: RST_ALERT_MASK, nominal: RST_NOMINAL,
                                  ceiling: RST_CEILING, upper: RST_UPPER,
                                  lower: RST_LOWER};
        end
    endfunction

    logic [7:0]  opCode;
    logic [7:0]  opPage;
    logic        isPlus;
    logic        refuse;

    always_comb begin
        isPlus = (req.kind == REQ_PLUS_WRITE) || (req.kind == REQ_PLUS_READ);
        opCode = isPlus ? req.embCode : req.code;
        opPage = isPlus ? req.page : cur.chanSel;
    end

    always_comb begin
        next_st = cur;
        refuse = 1'b0;
        next_st.rsp.valid = 1'b0;
        next_st.rsp.nack = 1'b0;
        next_st.runMeta = runPin;
        next_st.runSync = cur.runMeta;
        if (cur.busyCnt != '0) begin
            next_st.busyCnt = cur.busyCnt - 1'b1;
        end else begin
            next_st.mode = MODE_IDLE;
        end
        if (reqValid) begin
            next_st.rsp.valid = 1'b1;
            next_st.rsp.data = 16'h0000;
            if (cur.mode == MODE_NVM) begin
                next_st.fault.busy = 1'b1;
                next_st.rsp.nack = 1'b1;
            end else if (req.pecSent && !req.pecGood) begin
                next_st.fault.pec = 1'b1;
                next_st.rsp.nack = 1'b1;
            end else begin
                case (req.kind)
                    REQ_SEND: begin
                        case (req.code)
                            CMD_FAULT_CLEAR: next_st.fault = '0;
                            CMD_NVM_SAVE: begin
                                next_st.image = cur.user;
                                next_st.busyCnt = BUSY_LOAD;
                                next_st.mode = MODE_NVM;
                            end
                            CMD_NVM_RELOAD: begin
                                next_st.user = cur.image;
                                next_st.busyCnt = BUSY_LOAD;
                                next_st.mode = MODE_NVM;
                            end
                            default: refuse = 1'b1;
                        endcase
                    end
                    REQ_WRITE, REQ_PLUS_WRITE: begin
                        if (opCode == CMD_CHANNEL_SELECT && !isPlus) begin
                            if (!guardOk(cur.user.guard, opCode)) begin
                                refuse = 1'b1;
                            end else if (req.data[7:0] < 8'h02 || req.data[7:0] == PAGE_ALL) begin
                                next_st.chanSel = req.data[7:0];
                            end else begin
                                refuse = 1'b1;
                            end
                        end else if (opCode == CMD_GUARD_LEVEL) begin
                            case (req.data[7:0])
                                GUARD_ALL, GUARD_OP, GUARD_BASIC, RST_GUARD:
                                    next_st.user.guard = req.data[7:0];
                                default: refuse = 1'b1;
                            endcase
                        end else if (isChanCode(opCode) && guardOk(cur.user.guard, opCode)) begin
                            if (opPage == PAGE_ALL) begin
                                for (int i = 0; i < 2; i++) begin
                                    next_st.user.chan[i] =
                                        chanWrite(cur.user.chan[i], opCode, req.data);
                                end
                            end else if (opPage < 8'h02) begin
                                next_st.user.chan[opPage[0]] =
                                    chanWrite(cur.user.chan[opPage[0]], opCode, req.data);
                            end else begin
                                refuse = 1'b1;
                            end
                        end else begin
                            refuse = 1'b1;
                        end
                    end
                    REQ_READ, REQ_PLUS_READ: begin
                        if (opCode == CMD_CHANNEL_SELECT && !isPlus) begin
                            next_st.rsp.data = {8'h00, cur.chanSel};
                        end else if (opCode == CMD_GUARD_LEVEL) begin
                            next_st.rsp.data = {8'h00, cur.user.guard};
                        end else if (opCode == CMD_FEATURES) begin
                            next_st.rsp.data = {8'h00, FEATURES_VALUE};
                        end else if (opCode == CMD_FORMAT_EXP) begin
                            next_st.rsp.data = {8'h00, FORMAT_VALUE};
                        end else if (isChanCode(opCode) && opPage < 8'h02) begin
                            next_st.rsp.data = chanRead(cur.user.chan[opPage[0]], opCode);
                        end else begin
                            refuse = 1'b1;
                        end
                    end
                    default: refuse = 1'b1;
                endcase
                if (refuse) begin
                    next_st.fault.commMemoryLogicFault = 1'b1;
                    next_st.rsp.nack = 1'b1;
                end
            end
        end
        for (int i = 0; i < 2; i++) begin
            next_st.target[i] = setpoint(cur.user.chan[i]);
            next_st.enable[i] = chanOn(cur.user.chan[i], cur.runSync[i]);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur.user <= userReset();
            cur.image <= userReset();
            cur.chanSel <= RST_CHANNEL;
            cur.fault <= '0;
            cur.rsp <= '0;
            cur.busyCnt <= '0;
            cur.mode <= MODE_IDLE;
            cur.runMeta <= 2'h0;
            cur.runSync <= 2'h0;
            cur.enable <= 2'h0;
            cur.target <= '0;
        end else begin
            cur <= next_st;
        end
    end

    assign reqReady = (cur.mode == MODE_IDLE);
    assign rsp = cur.rsp;
    assign chanEnable = cur.enable;
    assign chanTarget = cur.target;
    assign fault = cur.fault;
    assign alertMask = {cur.user.chan[1].alertMask, cur.user.chan[0].alertMask};

    logic reqOk;
    assign reqOk = reqValid && cur.mode == MODE_IDLE && !(req.pecSent && !req.pecGood);

    chk_reserved_refused: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_WRITE && req.code >= CMD_RESERVED_BASE
        |=> rsp.valid && rsp.nack && fault.commMemoryLogicFault)
        else $error("reserved write not refused");
    chk_unsup_read: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_READ && req.code == 8'h04
        |=> rsp.nack && rsp.data == 16'h0000)
        else $error("unsupported read answered");
    chk_fault_sticky: assert property (@(posedge core_clk) disable iff (rst)
        fault.commMemoryLogicFault &&
        !(reqOk && req.kind == REQ_SEND && req.code == CMD_FAULT_CLEAR)
        |=> fault.commMemoryLogicFault)
        else $error("fault flag lost");
    chk_format_value: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_READ && req.code == CMD_FORMAT_EXP
        |=> rsp.valid && !rsp.nack && rsp.data == 16'h0014)
        else $error("format query wrong");
    chk_busy_refusal: assert property (@(posedge core_clk) disable iff (rst)
        reqValid && !reqReady |=> rsp.nack && fault.busy)
        else $error("busy request not refused");
    chk_clear_all: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_SEND && req.code == CMD_FAULT_CLEAR |=> fault == '0)
        else $error("faults not cleared");
    chk_direct_keeps: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_PLUS_WRITE |=> $stable(cur.chanSel))
        else $error("direct write moved selection");
    chk_features: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_READ && req.code == CMD_FEATURES |=> rsp.data == 16'h00B0)
        else $error("feature byte wrong");
    chk_ceiling_clamp: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> chanTarget[1] <= $past(cur.user.chan[1].ceiling))
        else $error("set point above ceiling");
    chk_save_image: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_SEND && req.code == CMD_NVM_SAVE
        |=> cur.image == $past(cur.user) ##1 !reqReady)
        else $error("save did not copy");
    chk_pec_refusal: assert property (@(posedge core_clk) disable iff (rst)
        reqValid && reqReady && req.pecSent && !req.pecGood
        |=> rsp.nack && fault.pec && $stable(cur.user))
        else $error("bad check byte acted on");
    chk_read_keeps: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_PLUS_READ |=> $stable(cur.chanSel))
        else $error("direct read moved selection");
    chk_select_write: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_WRITE && req.code == CMD_CHANNEL_SELECT &&
        cur.user.guard == RST_GUARD && req.data[7:0] < 8'h02
        |=> cur.chanSel == $past(req.data[7:0]))
        else $error("selection not taken");
    chk_guard_blocks: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_WRITE && cur.user.guard == GUARD_ALL &&
        req.code != CMD_GUARD_LEVEL |=> rsp.nack && $stable(cur.user.chan))
        else $error("guarded write applied");
    chk_reload_copy: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_SEND && req.code == CMD_NVM_RELOAD
        |=> cur.user == $past(cur.image))
        else $error("reload did not copy");
    chk_free_enable: assert property (@(posedge core_clk) disable iff (rst)
        !cur.user.chan[1].onSource[ONOFF_HONOR_BIT] |=> chanEnable[1])
        else $error("free-running channel off");
    chk_paged_copy: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_WRITE && isChanCode(req.code) && cur.chanSel == 8'h01
        |=> $stable(cur.user.chan[0]))
        else $error("other channel changed");
    chk_nominal_write: assert property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_WRITE && req.code == CMD_NOMINAL &&
        cur.chanSel == 8'h01 && cur.user.guard == RST_GUARD
        |=> cur.user.chan[1].nominal == $past(req.data))
        else $error("nominal write lost");
    chk_margin_pick: assert property (@(posedge core_clk) disable iff (rst)
        cur.user.chan[1].runMode[OP_MARGIN_LSB +: 2] == MARGIN_HIGH &&
        cur.user.chan[1].upper <= cur.user.chan[1].ceiling
        |=> chanTarget[1] == $past(cur.user.chan[1].upper))
        else $error("upper margin not applied");

    cov_margin_high: cover property (@(posedge core_clk) disable iff (rst)
        cur.user.chan[1].runMode[OP_MARGIN_LSB +: 2] == MARGIN_HIGH);
    cov_reload_done: cover property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_SEND && req.code == CMD_NVM_RELOAD);
    cov_guard_refused: cover property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_WRITE && cur.user.guard == GUARD_ALL);
    cov_busy_hit: cover property (@(posedge core_clk) disable iff (rst)
        reqValid && !reqReady);
    cov_direct_read: cover property (@(posedge core_clk) disable iff (rst)
        reqOk && req.kind == REQ_PLUS_READ);
endmodule

/* test/pcd_host_model.sv */
`timescale 1ns/1ps
module pcd_host_model
    import pcd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reqReady,
    input  wire pcd_pkg::pcd_rsp_t rsp,
    output logic                   reqValid,
    output pcd_pkg::pcd_req_t      req
);
    initial begin
        reqValid = 1'b0;
        req = '0;
    end
    // One command; pec 00 none, 11 good, 10 bad; rude skips busy wait and range guard
    task automatic issue(input pcd_kind_t kind, input logic [7:0] code, input logic [7:0] page,
                         input logic [7:0] emb, input logic [15:0] data, input logic [1:0] pec,
                         input logic rude, output pcd_rsp_t got);
        int waitCnt;
        waitCnt = 0;
        got = '0;
        if (!rude && code >= CMD_RESERVED_BASE) begin
            return;
        end
        @(negedge core_clk);
        while (!rude && reqReady !== 1'b1 && waitCnt < 300) begin
            waitCnt++;
            @(negedge core_clk);
        end
        req.kind = kind;
        req.code = code;
        req.page = page;
        req.embCode = emb;
        req.data = data;
        req.pecSent = pec[1];
        req.pecGood = pec[0];
        reqValid = 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        got = rsp;
        reqValid = 1'b0;
        // Released lines must not keep the last value
        req = ~req;
    endtask
endmodule

/* test/pcd_command_decoder_tb_top.sv */
`timescale 1ns/1ps
module pcd_command_decoder_tb_top;
    import pcd_pkg::*;
    localparam int BUSY = 4;
    logic             core_clk;
    logic             rst;
    logic             reqValid;
    logic             reqReady;
    pcd_req_t         req;
    pcd_rsp_t         rsp;
    pcd_rsp_t         got;
    logic [1:0]       runPin;
    logic [1:0]       chanEnable;
    logic [1:0][15:0] chanTarget;
    logic [1:0][7:0]  alertMask;
    pcd_fault_t       fault;
    int               fails;
    int               samplesChecked;
    int               cycles;
    logic [31:0]      seed;
    logic [15:0]      nom [2];
    logic [7:0]       codes [10];
    logic [15:0]      dflt [10];
    logic [7:0]       modes [3];
    logic [15:0]      want [3];

    pcd_command_decoder #(.BUSY_CYCLES(BUSY)) uut (
        .core_clk(core_clk), .rst(rst), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .rsp(rsp), .runPin(runPin), .chanEnable(chanEnable),
        .chanTarget(chanTarget), .alertMask(alertMask), .fault(fault));
    pcd_host_model host (.core_clk(core_clk), .reqReady(reqReady), .rsp(rsp),
        .reqValid(reqValid), .req(req));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic printVerdict();
        $display("checks %0d fails %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmd(input pcd_kind_t k, input logic [7:0] c, input logic [15:0] d,
                       input logic [1:0] pec = 2'b00, input logic rude = 1'b0);
        host.issue(k, c, 8'h00, 8'h00, d, pec, rude, got);
    endtask
    task automatic settle();
        repeat (4) @(negedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            printVerdict();
        end
    end

    initial begin
        rst = 1'b1;
        runPin = 2'b00;
        seed = 32'h03260034;
        codes = '{CMD_RUN_MODE, CMD_ON_SOURCE, CMD_GUARD_LEVEL, CMD_FEATURES, CMD_ALERT_MASK,
                  CMD_FORMAT_EXP, CMD_NOMINAL, CMD_CEILING, CMD_UPPER_MARGIN, CMD_LOWER_MARGIN};
        dflt = '{16'(RST_RUN_MODE), 16'(RST_ON_SOURCE), 16'(RST_GUARD), 16'(FEATURES_VALUE),
                 16'(RST_ALERT_MASK), 16'(FORMAT_VALUE), RST_NOMINAL, RST_CEILING,
                 RST_UPPER, RST_LOWER};
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        // Target and enable outputs hold zero until the first edge after release
        settle();
        check(chanTarget[0], RST_NOMINAL);
        check({15'h0, chanEnable[0]}, 16'h0000);
        // Defaults on both channels, channel select echoes
        for (int p = 0; p < 2; p++) begin
            cmd(REQ_WRITE, CMD_CHANNEL_SELECT, 16'(p));
            cmd(REQ_READ, CMD_CHANNEL_SELECT, 16'h0000);
            check({7'h00, got.valid, got.data[7:0]}, {8'h01, 8'(p)});
            for (int i = 0; i < 10; i++) begin
                cmd(REQ_READ, codes[i], 16'h0000);
                check(i < 6 ? {8'h00, got.data[7:0]} : got.data, dflt[i]);
            end
        end
        // Random nominals kept inside the margins by the host
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            nom[p] = 16'h0F40 + {8'h00, seed[7:0]};
            host.issue(REQ_PLUS_WRITE, CMD_DIRECT_WRITE, 8'(p), CMD_NOMINAL, nom[p], 2'b00,
                       1'b0, got);
        end
        for (int p = 0; p < 2; p++) begin
            host.issue(REQ_PLUS_READ, CMD_DIRECT_READ, 8'(p), CMD_NOMINAL, 16'h0, 2'b00,
                       1'b0, got);
            check(got.data, nom[p]);
        end
        cmd(REQ_READ, CMD_CHANNEL_SELECT, 16'h0000);
        check({8'h00, got.data[7:0]}, 16'h0001);
        settle();
        check(chanTarget[0], nom[0]);
        // Run modes on channel 1 with both run pins high
        runPin = 2'b11;
        modes = '{8'h80, 8'h90, 8'hA0};
        want = '{nom[1], RST_LOWER, RST_UPPER};
        for (int i = 0; i < 3; i++) begin
            cmd(REQ_WRITE, CMD_RUN_MODE, {8'h00, modes[i]});
            settle();
            check(chanTarget[1], want[i]);
            check({15'h0, chanEnable[1]}, 16'h0001);
        end
        cmd(REQ_WRITE, CMD_CEILING, 16'h1000);
        settle();
        check(chanTarget[1], 16'h1000);
        runPin[1] = 1'b0;
        settle();
        check({15'h0, chanEnable[1]}, 16'h0000);
        cmd(REQ_WRITE, CMD_ON_SOURCE, 16'h0000);
        settle();
        check({15'h0, chanEnable[1]}, 16'h0001);
        cmd(REQ_WRITE, CMD_ALERT_MASK, 16'h00A5);
        check({8'h00, alertMask[1]}, 16'h00A5);
        check({8'h00, alertMask[0]}, 16'h0000);
        // Unsupported, reserved and read-only accesses
        for (int i = 0; i < 3; i++) begin
            cmd(i == 0 ? REQ_READ : REQ_WRITE, i == 0 ? 8'h04 : i == 1 ? 8'hD5 : CMD_FEATURES,
                16'h0055, 2'b00, 1'b1);
            check({15'h0, got.nack}, 16'h0001);
            check({13'h0, fault}, 16'h0004);
            cmd(REQ_SEND, CMD_FAULT_CLEAR, 16'h0000);
            check({13'h0, fault}, 16'h0000);
        end
        // Bad check byte must leave the value alone
        cmd(REQ_WRITE, CMD_NOMINAL, 16'h0F99, 2'b10);
        check({12'h0, got.nack, fault}, 16'h0009);
        cmd(REQ_READ, CMD_NOMINAL, 16'h0000);
        check(got.data, nom[1]);
        cmd(REQ_WRITE, CMD_NOMINAL, nom[1], 2'b11);
        check({15'h0, got.nack}, 16'h0000);
        cmd(REQ_SEND, CMD_FAULT_CLEAR, 16'h0000);
        // Guard blocks set point writes
        cmd(REQ_WRITE, CMD_GUARD_LEVEL, {8'h00, GUARD_ALL});
        cmd(REQ_WRITE, CMD_NOMINAL, 16'h0F70);
        check({15'h0, got.nack}, 16'h0001);
        cmd(REQ_WRITE, CMD_GUARD_LEVEL, 16'h0000);
        cmd(REQ_SEND, CMD_FAULT_CLEAR, 16'h0000);
        // Save, busy refusal, then reload
        cmd(REQ_SEND, CMD_NVM_SAVE, 16'h0000);
        check({15'h0, reqReady}, 16'h0000);
        cmd(REQ_READ, CMD_NOMINAL, 16'h0000, 2'b00, 1'b1);
        check({14'h0, got.nack, fault.busy}, 16'h0003);
        // Busy holds one cycle past the loaded count
        repeat (BUSY - 2) @(negedge core_clk);
        check({15'h0, reqReady}, 16'h0000);
        @(negedge core_clk);
        check({15'h0, reqReady}, 16'h0001);
        cmd(REQ_WRITE, CMD_NOMINAL, 16'h0F77);
        cmd(REQ_SEND, CMD_NVM_RELOAD, 16'h0000);
        cmd(REQ_READ, CMD_NOMINAL, 16'h0000);
        check(got.data, nom[1]);
        cmd(REQ_READ, CMD_CEILING, 16'h0000);
        check(got.data, 16'h1000);
        printVerdict();
    end
endmodule
